// [hdl/frc_timer.sv]
// Free-running counter with read latch and barcode trigger capture.
`timescale 1ns/1ps
module frc_timer #(
	parameter int TICK_DIV = hio_pkg::TICK_CYCLES,
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire hio_pkg::trig_mode_t mode,
	input wire logic barcode,
	input wire logic latch,
	output logic [WIDTH-1:0] count,
	output logic ovf,
	output logic trig,
	output logic [WIDTH-1:0] rcap,
	output logic [WIDTH-1:0] tcap
);
	localparam logic [7:0] DIV_LAST = 8'(TICK_DIV - 1);

	typedef struct packed {
		logic [7:0] div;
		logic [WIDTH-1:0] count;
		logic ovf;
		logic trig;
		logic bc_prev;
		logic [WIDTH-1:0] rcap;
		logic [WIDTH-1:0] tcap;
	} tst_t;

	tst_t st;
	tst_t next;
	logic edge_hit;

	// ==================================================================
	// Next state
	always_comb
	begin
		next = st;
		edge_hit = 1'b0;
		next.ovf = 1'b0;
		next.trig = 1'b0;
		next.bc_prev = barcode;
		// R12: prescaled tick advances counter
		if (st.div == DIV_LAST)
		begin
			next.div = 8'h00;
			next.count = st.count + 1'b1;
			next.ovf = &st.count;
		end
		else
			next.div = st.div + 8'h01;
		// R14: mode-qualified barcode edge
		case (mode)
			hio_pkg::TRIG_RISE: edge_hit = barcode & ~st.bc_prev;
			hio_pkg::TRIG_FALL: edge_hit = ~barcode & st.bc_prev;
			hio_pkg::TRIG_BOTH: edge_hit = barcode ^ st.bc_prev;
			default: edge_hit = 1'b0;
		endcase
		if (edge_hit)
		begin
			next.trig = 1'b1;
			next.tcap = st.count;
		end
		// R11: host read freezes count
		if (latch)
			next.rcap = st.count;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next;
	end

	assign count = st.count;
	assign ovf = st.ovf;
	assign trig = st.trig;
	assign rcap = st.rcap;
	assign tcap = st.tcap;

	// ==================================================================
	// Checks
	property p_count_step;
		@(posedge clk) disable iff (rst)
		(st.count != $past(st.count))
			|-> (st.count == WIDTH'($past(st.count) + 1'b1));
	endproperty
	a_count_step: assert property (p_count_step) // R12
		else $error("counter moved by other than one");

	property p_ovf_wrap;
		@(posedge clk) disable iff (rst)
		st.ovf |-> (st.count == '0) && $past(&st.count);
	endproperty
	a_ovf_wrap: assert property (p_ovf_wrap) // R12
		else $error("overflow without wrap");

	property p_trig_cap;
		@(posedge clk) disable iff (rst)
		st.trig |-> (st.tcap == $past(st.count));
	endproperty
	a_trig_cap: assert property (p_trig_cap) // R14
		else $error("trigger capture holds wrong count");
endmodule // frc_timer

// [hdl/host_io_array.sv]
// Host I/O gate array: decoder, vectored interrupts, timer, shift handshake.
// Functional notes
// R01: control bit 0 selects memory map
// R02: control holds baud select, barcode power
// R03: command writes pulse-clear/set flags
// R04: ready flag set gives host the buffer
// R05: ready clear interrupts the sub-processor
// R06: host updates ready after each access
// R07: owner output high means sub-processor
// R08: shift buffer clocked by sub-processor clock
// R09: port bits drive line and lamp outputs
// R10: software inhibits line while supply settles
// R11: read 00 latches count, 01 high
// R12: prescaled clock counts; wrap flags overflow
// R13: low counter bits make line clocks
// R14: barcode mode edge captures count, flags
// R15: per-source enable mask gates requests
// R16: pending read shows six sources, top zero
// R17: source 0 highest, vectors step two
// R18: acknowledge returns top enabled vector
// R19: vector only when fetch and request
// R20: status shows ready, sub ready, barcode, bank
// R21: low lines pick registers, upper lines chip selects
// R22: power-off floats all outputs
// R23: host request while enabled source pending
`timescale 1ns/1ps
module host_io_array #(
	parameter int TICK_DIV = hio_pkg::TICK_CYCLES
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic OFF,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] DB_IN,
	output logic [7:0] DB_OUT,
	output logic DB_OE,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic IORQ_N,
	input wire logic M1_N,
	input wire logic SUBPROC_IRQ_N,
	input wire logic SERIAL_IRQ_N,
	input wire logic SLAVE_IRQ_N,
	input wire logic EXPANSION_IRQ_N,
	input wire logic SUBPROC_READY,
	input wire logic BARCODE_DATA,
	input wire logic SHIFT_CLOCK,
	input wire logic SHIFT_IN,
	output logic SHIFT_OUT,
	output logic SHIFT_BUFFER_OWNER,
	output logic SUBPROC_INTERRUPT_OUT,
	output logic HOST_IRQ,
	output logic MEMORY_MAP_SELECT,
	output logic BARCODE_POWER_SWITCH,
	output logic LINE_POWER_SWITCH,
	output logic LINE_OUTPUT_INHIBIT,
	output logic LINE_CONTROL_AUX,
	output logic KEYBOARD_LAMP_A,
	output logic KEYBOARD_LAMP_B,
	output logic KEYBOARD_LAMP_C,
	output logic TX_CLOCK,
	output logic RX_CLOCK,
	output logic SERIAL_CS_N,
	output logic LCD_CS_N,
	output logic PINS_OE
);
	typedef struct packed {
		hio_pkg::host_bus_t bus1;
		hio_pkg::host_bus_t bus2;
		logic [hio_pkg::NPIN-1:0] pin1;
		logic [hio_pkg::NPIN-1:0] pin2;
		logic rd_prev;
		logic wr_prev;
		logic sck_prev;
		logic [7:0] ctrl;
		logic [7:0] pwr;
		logic [5:0] mask;
		logic ready;
		logic owner;
		logic [7:0] shift;
		logic ovf_flag;
		logic icf_flag;
		logic [7:0] db_out;
		logic db_oe;
		logic irq;
		logic cs_ser_n;
		logic cs_lcd_n;
		logic lclk;
		logic pins_oe;
	} st_t;

	st_t st;
	st_t next;
	logic [5:0] pend;
	logic [3:0] ofs;
	logic [7:0] rdata;
	logic [2:0] baud;
	logic internal;
	logic io_rd;
	logic io_wr;
	logic rd_start;
	logic wr_start;
	logic vec_cyc;
	logic sck_rise;
	logic off;
	logic [15:0] count;
	logic ovf_p;
	logic trig_p;
	logic [15:0] rcap;
	logic [15:0] tcap;

	// ==================================================================
	// Priority vector
	// R17: lowest index wins, vector steps two
	function automatic logic [7:0] vector_of(input logic [5:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = hio_pkg::NSRC - 1; i >= 0; i--)
			if (req[i])
				idx = 3'(i);
		return hio_pkg::VEC_BASE + {4'h0, idx, 1'b0};
	endfunction

	// ==================================================================
	// Counter and capture
	frc_timer #(
		.TICK_DIV(TICK_DIV),
		.WIDTH(16)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.mode(hio_pkg::trig_mode_t'(
			st.ctrl[hio_pkg::CTRL_MODE_HI:hio_pkg::CTRL_MODE_LO])),
		.barcode(st.pin2[hio_pkg::PIN_BC]),
		.latch(rd_start && internal && ofs == hio_pkg::OFS_RCAP_L),
		.count(count),
		.ovf(ovf_p),
		.trig(trig_p),
		.rcap(rcap),
		.tcap(tcap)
	);

	// ==================================================================
	// Next state
	always_comb
	begin
		next = st;
		// Pins from other parties are synchronised before any use.
		next.bus1.addr = ADDR;
		next.bus1.data = DB_IN;
		next.bus1.rd = ~RD_N;
		next.bus1.wr = ~WR_N;
		next.bus1.iorq = ~IORQ_N;
		next.bus1.m1 = ~M1_N;
		next.bus2 = st.bus1;
		next.pin1[hio_pkg::PIN_OFF] = OFF;
		next.pin1[hio_pkg::PIN_SUB] = ~SUBPROC_IRQ_N;
		next.pin1[hio_pkg::PIN_SER] = ~SERIAL_IRQ_N;
		next.pin1[hio_pkg::PIN_SLV] = ~SLAVE_IRQ_N;
		next.pin1[hio_pkg::PIN_EXP] = ~EXPANSION_IRQ_N;
		next.pin1[hio_pkg::PIN_RDY] = SUBPROC_READY;
		next.pin1[hio_pkg::PIN_BC] = BARCODE_DATA;
		next.pin1[hio_pkg::PIN_SCK] = SHIFT_CLOCK;
		next.pin1[hio_pkg::PIN_SI] = SHIFT_IN;
		next.pin2 = st.pin1;

		off = st.pin2[hio_pkg::PIN_OFF];
		ofs = st.bus2.addr[3:0];
		// R21: upper lines pick page, low four register
		internal = st.bus2.addr[7:4] == hio_pkg::PAGE_INT;
		io_rd = st.bus2.iorq & st.bus2.rd & ~st.bus2.m1;
		io_wr = st.bus2.iorq & st.bus2.wr & ~st.bus2.m1;
		rd_start = io_rd & ~st.rd_prev;
		wr_start = io_wr & ~st.wr_prev;
		vec_cyc = st.bus2.iorq & st.bus2.m1;
		sck_rise = st.pin2[hio_pkg::PIN_SCK] & ~st.sck_prev;
		next.rd_prev = io_rd;
		next.wr_prev = io_wr;
		next.sck_prev = st.pin2[hio_pkg::PIN_SCK];

		pend[hio_pkg::SRC_SUB] = st.pin2[hio_pkg::PIN_SUB];
		pend[hio_pkg::SRC_SER] = st.pin2[hio_pkg::PIN_SER];
		pend[hio_pkg::SRC_SLV] = st.pin2[hio_pkg::PIN_SLV];
		pend[hio_pkg::SRC_ICF] = st.icf_flag;
		pend[hio_pkg::SRC_OVF] = st.ovf_flag;
		pend[hio_pkg::SRC_EXP] = st.pin2[hio_pkg::PIN_EXP];

		// Host register writes.
		if (wr_start && internal)
		begin
			case (ofs)
				// R01: bank bit and R02: baud, barcode power
				hio_pkg::OFS_CTRL: next.ctrl = st.bus2.data;
				// R03: command bits act only as pulses
				hio_pkg::OFS_CMD:
				begin
					if (st.bus2.data[hio_pkg::CMD_CLR_RDY])
						next.ready = 1'b0;
					if (st.bus2.data[hio_pkg::CMD_SET_RDY])
						next.ready = 1'b1;
					if (st.bus2.data[hio_pkg::CMD_CLR_OVF])
						next.ovf_flag = 1'b0;
				end
				// R09: port register drives pins
				hio_pkg::OFS_PWR: next.pwr = st.bus2.data;
				// R15: enable mask written
				hio_pkg::OFS_MASK: next.mask = st.bus2.data[5:0];
				// R04: host writes only while ready set
				hio_pkg::OFS_SHIFT:
					if (st.ready)
						next.shift = st.bus2.data;
				default: ;
			endcase
		end

		// Reading the trigger capture acknowledges the capture flag.
		if (rd_start && internal && ofs == hio_pkg::OFS_TCAP_L)
			next.icf_flag = 1'b0;
		// R12: overflow sets flag, beats clear
		if (ovf_p)
			next.ovf_flag = 1'b1;
		// R14: trigger sets capture flag
		if (trig_p)
			next.icf_flag = 1'b1;

		// R08: sub-processor clock shifts buffer
		if (sck_rise && !st.ready)
			next.shift = {st.shift[6:0], st.pin2[hio_pkg::PIN_SI]};

		// R05: cleared ready interrupts sub-processor
		// R07: owner high while ready clear
		next.owner = ~next.ready;

		// Register reads.
		case (ofs)
			// R11: low byte shown live on the latching cycle
			hio_pkg::OFS_RCAP_L: rdata = rd_start ? count[7:0] : rcap[7:0];
			hio_pkg::OFS_RCAP_H: rdata = rcap[15:8];
			hio_pkg::OFS_TCAP_L: rdata = tcap[7:0];
			hio_pkg::OFS_TCAP_H: rdata = tcap[15:8];
			// R16: pending sources, top bits zero
			hio_pkg::OFS_PEND: rdata = {2'b00, pend};
			// R20: status bits
			hio_pkg::OFS_STATUS:
			begin
				rdata = 8'h00;
				rdata[hio_pkg::ST_READY] = st.ready;
				rdata[hio_pkg::ST_SUB_RDY] = st.pin2[hio_pkg::PIN_RDY];
				rdata[hio_pkg::ST_BC] = st.pin2[hio_pkg::PIN_BC];
				rdata[hio_pkg::ST_BANK] = st.ctrl[hio_pkg::CTRL_BANK];
			end
			// R04: buffer hidden while sub-processor owns it
			hio_pkg::OFS_SHIFT: rdata = st.ready ? st.shift : 8'h00;
			default: rdata = 8'h00;
		endcase

		// R18: acknowledge returns winning vector
		// R19: only in fetch plus request cycle
		// R22: power-off keeps the bus floating
		next.db_oe = ~off & ((io_rd & internal) | vec_cyc);
		next.db_out = vec_cyc ? vector_of(pend & st.mask) : rdata;
		// R23: request while any enabled source pends
		next.irq = |(pend & st.mask);
		// R21: external chip selects from page decode
		next.cs_ser_n = ~((io_rd | io_wr) &&
			st.bus2.addr[7:4] == hio_pkg::PAGE_SERIAL);
		next.cs_lcd_n = ~((io_rd | io_wr) &&
			st.bus2.addr[7:4] == hio_pkg::PAGE_LCD);
		// R13: selected low counter bit is line clock
		baud = st.ctrl[hio_pkg::CTRL_BAUD_MSB] ? hio_pkg::BAUD_TOP :
			st.ctrl[hio_pkg::CTRL_BAUD_MSB-1:hio_pkg::CTRL_BAUD_LSB];
		next.lclk = count[baud];
		// R22: all output pins float while off
		next.pins_oe = ~off;
	end

	// ==================================================================
	// State register
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			st <= '0;
			st.ctrl <= hio_pkg::CTRL_RESET;
			st.pwr <= hio_pkg::PWR_RESET;
			st.mask <= hio_pkg::MASK_RESET;
			st.ready <= hio_pkg::RDY_RESET;
			st.owner <= ~hio_pkg::RDY_RESET;
			st.cs_ser_n <= 1'b1;
			st.cs_lcd_n <= 1'b1;
		end
		else
			st <= next;
	end

	// ==================================================================
	// Outputs
	assign DB_OUT = st.db_out;
	assign DB_OE = st.db_oe;
	assign SHIFT_OUT = st.shift[7];
	assign SHIFT_BUFFER_OWNER = st.owner;
	assign SUBPROC_INTERRUPT_OUT = st.owner;
	assign HOST_IRQ = st.irq;
	assign MEMORY_MAP_SELECT = st.ctrl[hio_pkg::CTRL_BANK];
	assign BARCODE_POWER_SWITCH = st.ctrl[hio_pkg::CTRL_BC_PWR];
	assign LINE_POWER_SWITCH = st.pwr[hio_pkg::PWR_LINE_SW];
	assign LINE_OUTPUT_INHIBIT = st.pwr[hio_pkg::PWR_INHIBIT];
	assign LINE_CONTROL_AUX = st.pwr[hio_pkg::PWR_AUX];
	assign KEYBOARD_LAMP_A = st.pwr[hio_pkg::PWR_LAMP_A];
	assign KEYBOARD_LAMP_B = st.pwr[hio_pkg::PWR_LAMP_B];
	assign KEYBOARD_LAMP_C = st.pwr[hio_pkg::PWR_LAMP_C];
	assign TX_CLOCK = st.lclk;
	assign RX_CLOCK = st.lclk;
	assign SERIAL_CS_N = st.cs_ser_n;
	assign LCD_CS_N = st.cs_lcd_n;
	assign PINS_OE = st.pins_oe;

	// ==================================================================
	// Checks
	property p_irq_follows;
		@(posedge CLK) disable iff (RST)
		(|(pend & st.mask)) |=> st.irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) // R23
		else $error("enabled pending source gave no host request");

	property p_ready_clear;
		@(posedge CLK) disable iff (RST)
		(wr_start && internal && ofs == hio_pkg::OFS_CMD &&
			st.bus2.data[hio_pkg::CMD_CLR_RDY] &&
			!st.bus2.data[hio_pkg::CMD_SET_RDY])
			|=> !st.ready && st.owner;
	endproperty
	a_ready_clear: assert property (p_ready_clear) // R05
		else $error("ready clear did not hand buffer over");

	property p_ovf_set;
		@(posedge CLK) disable iff (RST)
		ovf_p |=> st.ovf_flag;
	endproperty
	a_ovf_set: assert property (p_ovf_set) // R12
		else $error("overflow lost against clear");

	property p_vector;
		@(posedge CLK) disable iff (RST)
		(vec_cyc && !off && st.mask[hio_pkg::SRC_SUB] &&
			pend[hio_pkg::SRC_SUB])
			|=> st.db_oe && st.db_out == hio_pkg::VEC_BASE;
	endproperty
	a_vector: assert property (p_vector) // R17
		else $error("top source vector wrong");

	property p_mask_write;
		@(posedge CLK) disable iff (RST)
		(wr_start && internal && ofs == hio_pkg::OFS_MASK)
			|=> st.mask == $past(st.bus2.data[5:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) // R15
		else $error("enable mask not stored");

	property p_off_float;
		@(posedge CLK) disable iff (RST)
		off |=> !st.pins_oe && !st.db_oe;
	endproperty
	a_off_float: assert property (p_off_float) // R22
		else $error("outputs driven while powered off");

	property p_pend_top;
		@(posedge CLK) disable iff (RST)
		(io_rd && internal && !vec_cyc && ofs == hio_pkg::OFS_PEND)
			|=> st.db_out[7:6] == 2'b00;
	endproperty
	a_pend_top: assert property (p_pend_top) // R16
		else $error("pending top bits not zero");

	property p_shift_in;
		@(posedge CLK) disable iff (RST)
		(sck_rise && !st.ready)
			|=> st.shift == {$past(st.shift[6:0]),
				$past(st.pin2[hio_pkg::PIN_SI])};
	endproperty
	a_shift_in: assert property (p_shift_in) // R08
		else $error("shift buffer did not shift");
endmodule // host_io_array

// [shared/hio_pkg.sv]
// Shared constants and types for the host I/O interrupt and timer array.
package hio_pkg;
	// ==================================================================
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int EXT_HZ = 2_457_600;
	localparam int EXT_PRESCALE = 4;
	localparam int TICK_HZ = EXT_HZ / EXT_PRESCALE;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	// ==================================================================
	// Register offsets on the four low address lines
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CMD = 4'h1;
	localparam logic [3:0] OFS_PWR = 4'h2;
	localparam logic [3:0] OFS_MASK = 4'h4;
	localparam logic [3:0] OFS_RCAP_L = 4'h0;
	localparam logic [3:0] OFS_RCAP_H = 4'h1;
	localparam logic [3:0] OFS_TCAP_L = 4'h2;
	localparam logic [3:0] OFS_TCAP_H = 4'h3;
	localparam logic [3:0] OFS_PEND = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	localparam logic [3:0] OFS_SHIFT = 4'h6;
	localparam logic [3:0] PAGE_INT = 4'h0;
	localparam logic [3:0] PAGE_SERIAL = 4'h1;
	localparam logic [3:0] PAGE_LCD = 4'h2;
	// ==================================================================
	// Field positions
	localparam int CTRL_BANK = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_MODE_HI = 2;
	localparam int CTRL_BC_PWR = 3;
	localparam int CTRL_BAUD_LSB = 4;
	localparam int CTRL_BAUD_MSB = 7;
	localparam int CMD_SET_RDY = 0;
	localparam int CMD_CLR_RDY = 1;
	localparam int CMD_CLR_OVF = 2;
	localparam int PWR_LAMP_A = 0;
	localparam int PWR_LAMP_B = 1;
	localparam int PWR_LAMP_C = 2;
	localparam int PWR_LINE_SW = 3;
	localparam int PWR_INHIBIT = 4;
	localparam int PWR_AUX = 5;
	localparam int ST_BANK = 0;
	localparam int ST_BC = 1;
	localparam int ST_SUB_RDY = 2;
	localparam int ST_READY = 3;
	localparam int NSRC = 6;
	localparam int SRC_SUB = 0;
	localparam int SRC_SER = 1;
	localparam int SRC_SLV = 2;
	localparam int SRC_ICF = 3;
	localparam int SRC_OVF = 4;
	localparam int SRC_EXP = 5;
	localparam int NPIN = 9;
	localparam int PIN_OFF = 0;
	localparam int PIN_SUB = 1;
	localparam int PIN_SER = 2;
	localparam int PIN_SLV = 3;
	localparam int PIN_EXP = 4;
	localparam int PIN_RDY = 5;
	localparam int PIN_BC = 6;
	localparam int PIN_SCK = 7;
	localparam int PIN_SI = 8;
	// ==================================================================
	// Values
	localparam logic [7:0] VEC_BASE = 8'hf0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PWR_RESET = 8'h00;
	localparam logic [5:0] MASK_RESET = 6'h00;
	localparam logic RDY_RESET = 1'b1;
	localparam logic [2:0] BAUD_TOP = 3'h7;
	// ==================================================================
	// Types
	typedef enum logic [1:0] {
		TRIG_OFF = 2'h0,
		TRIG_RISE = 2'h1,
		TRIG_FALL = 2'h2,
		TRIG_BOTH = 2'h3
	} trig_mode_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic rd;
		logic wr;
		logic iorq;
		logic m1;
	} host_bus_t;
endpackage

// [verif/subproc_model.sv]
// Behavioural sub-processor end of the serial shift handshake.
`timescale 1ns/1ps
module subproc_model (
	input wire logic clk,
	input wire logic owner,
	input wire logic shift_out,
	output logic sck,
	output logic si,
	output logic ready
);
	// ==================================================================
	// Idle state
	// The shift clock stands still between bytes, as the real part does.
	initial
	begin
		sck = 1'b0;
		si = 1'b0;
	end

	// The sub-processor reports itself busy while it holds the buffer.
	always @(posedge clk)
		ready <= ~owner;

	// ==================================================================
	// Byte exchange
	// msb first shifting
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		int i;
		for (i = 7; i >= 0; i--)
		begin
			@(posedge clk);
			si <= tx[i];
			repeat (4) @(posedge clk);
			rx[i] = shift_out;
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		// Released data line shows the inverse so a stale bit cannot pass.
		si <= ~si;
	endtask
endmodule // subproc_model

// [verif/tb_host_io_array.sv]
// Self-checking bench for the host I/O interrupt and timer array.
`timescale 1ns/1ps
module tb_host_io_array;
	logic clk, rst, off, rd_n, wr_n, iorq_n, m1_n, barcode;
	logic [7:0] addr, db_in, db_out, q, r;
	logic [5:0] src_n;
	logic [15:0] v1, v2, d;
	logic db_oe, sck, si, shift_out, owner, sub_int, host_irq, sub_rdy;
	logic map_sel, bc_pwr, line_sw, inhibit, aux, lamp_a, lamp_b, lamp_c;
	logic tx_clk, rx_clk, ser_cs_n, lcd_cs_n, pins_oe;
	logic [2:0] srcs [4];
	logic [7:0] pv [3];
	int mismatches = 0, cmp_count = 0, cycles = 0, t0, i;
	// A one-cycle tick lets the counter wrap within the run.
	localparam int TDIV = 1;

	host_io_array #(.TICK_DIV(TDIV)) dut (.CLK(clk), .RST(rst),
		.OFF(off), .ADDR(addr),
		.DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .RD_N(rd_n),
		.WR_N(wr_n), .IORQ_N(iorq_n), .M1_N(m1_n),
		.SUBPROC_IRQ_N(src_n[0]), .SERIAL_IRQ_N(src_n[1]),
		.SLAVE_IRQ_N(src_n[2]), .EXPANSION_IRQ_N(src_n[5]),
		.SUBPROC_READY(sub_rdy), .BARCODE_DATA(barcode), .SHIFT_CLOCK(sck),
		.SHIFT_IN(si), .SHIFT_OUT(shift_out), .SHIFT_BUFFER_OWNER(owner),
		.SUBPROC_INTERRUPT_OUT(sub_int), .HOST_IRQ(host_irq),
		.MEMORY_MAP_SELECT(map_sel), .BARCODE_POWER_SWITCH(bc_pwr),
		.LINE_POWER_SWITCH(line_sw), .LINE_OUTPUT_INHIBIT(inhibit),
		.LINE_CONTROL_AUX(aux), .KEYBOARD_LAMP_A(lamp_a),
		.KEYBOARD_LAMP_B(lamp_b), .KEYBOARD_LAMP_C(lamp_c),
		.TX_CLOCK(tx_clk), .RX_CLOCK(rx_clk), .SERIAL_CS_N(ser_cs_n),
		.LCD_CS_N(lcd_cs_n), .PINS_OE(pins_oe));
	subproc_model sub (.clk(clk), .owner(owner), .shift_out(shift_out),
		.sck(sck), .si(si), .ready(sub_rdy));

	// ==================================================================
	// Clock and run limit
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 32'h13880)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	// ==================================================================
	// Bus tasks and comparison
	task automatic report_and_stop();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus_on(input logic [7:0] a, input logic [7:0] dv,
		input logic rd, input logic m1);
		@(posedge clk);
		addr <= a;
		db_in <= dv;
		iorq_n <= 1'b0;
		rd_n <= ~rd;
		wr_n <= rd | m1;
		m1_n <= ~m1;
	endtask
	// Strobes drop together; the gap lets the synchronisers see idle.
	task automatic bus_off();
		@(posedge clk);
		iorq_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		m1_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
	task automatic wait_oe(output logic [7:0] v);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end while (db_oe !== 1'b1 && n < 20);
		chk("db_oe", 8'h01, {7'h00, db_oe});
		v = db_out;
	endtask
	task automatic io_write(input logic [7:0] a, input logic [7:0] dv);
		bus_on(a, dv, 1'b0, 1'b0);
		repeat (6) @(posedge clk);
		bus_off();
	endtask
	task automatic io_read(input logic [7:0] a, output logic [7:0] v);
		bus_on(a, 8'h00, 1'b1, 1'b0);
		wait_oe(v);
		bus_off();
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] v;
		io_read(a, v);
		chk(nm, e, v);
	endtask
	task automatic vec_ack(output logic [7:0] v);
		bus_on(8'h00, 8'h00, 1'b0, 1'b1);
		wait_oe(v);
		bus_off();
	endtask

	// ==================================================================
	// Scenarios
	initial
	begin
		rst = 1'b1; off = 1'b0; rd_n = 1'b1; wr_n = 1'b1; iorq_n = 1'b1;
		m1_n = 1'b1; addr = 8'h00; db_in = 8'h00; barcode = 1'b0;
		src_n = 6'h3f;
		srcs = '{3'h0, 3'h1, 3'h2, 3'h5};
		pv = '{8'h15, 8'h1d, 8'h2a};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("reset outs", 8'h08, {4'h0, pins_oe, owner, sub_int, host_irq});
		rdchk(8'h05, 8'h0c, "status");
		io_write(8'h00, 8'h09);
		chk("map and bc power", 8'h03, {6'h00, bc_pwr, map_sel});
		rdchk(8'h05, 8'h0d, "status bank");
		// Inhibit is raised before, and held while, the line supply comes up.
		for (i = 0; i < 3; i++)
		begin
			io_write(8'h02, pv[i]);
			chk("port bits", pv[i],
				{2'h0, aux, inhibit, line_sw, lamp_c, lamp_b, lamp_a});
		end
		for (i = 0; i < 3; i++)
		begin
			io_write(8'h00, {i[3:0], 4'h9});
			@(posedge clk);
			#1;
			q[0] = tx_clk;
			chk("rx clock", {7'h00, q[0]}, {7'h00, rx_clk});
			repeat (TDIV << i) @(posedge clk);
			#1;
			chk("tx toggle", {7'h00, ~q[0]}, {7'h00, tx_clk});
		end
		// Two latching reads launched exactly forty ticks apart.
		@(posedge clk);
		t0 = cycles;
		io_read(8'h00, q);
		io_read(8'h01, r);
		v1 = {r, q};
		while (cycles < t0 + TDIV * 40) @(posedge clk);
		io_read(8'h00, q);
		io_read(8'h01, r);
		v2 = {r, q};
		d = v2 - v1;
		chk("count step lo", 8'h28, d[7:0]);
		chk("count step hi", 8'h00, d[15:8]);
		for (i = 0; i < 4; i++)
		begin
			io_write(8'h00, {4'h0, 1'b1, i[1:0], 1'b1});
			barcode <= 1'b1;
			repeat (6) @(posedge clk);
			rdchk(8'h04, {4'h0, i[0], 3'h0}, "pending rise");
			chk("irq masked", 8'h00, {7'h00, host_irq});
			rdchk(8'h05, 8'h0f, "status barcode");
			io_read(8'h02, q);
			barcode <= 1'b0;
			repeat (6) @(posedge clk);
			rdchk(8'h04, {4'h0, i[1], 3'h0}, "pending fall");
			io_read(8'h02, q);
		end
		for (i = 0; i < 4; i++)
		begin
			src_n[srcs[i]] <= 1'b0;
			io_write(8'h04, 8'h3f);
			vec_ack(q);
			chk("vector", hio_pkg::VEC_BASE + {srcs[i], 1'b0}, q);
			rdchk(8'h04, 8'h01 << srcs[i], "pending src");
			chk("irq on", 8'h01, {7'h00, host_irq});
			io_write(8'h04, 8'h00);
			chk("irq off", 8'h00, {7'h00, host_irq});
			src_n[srcs[i]] <= 1'b1;
		end
		src_n <= 6'h00;
		io_write(8'h04, 8'h3e);
		vec_ack(q);
		chk("vector prio", 8'hf2, q);
		io_write(8'h04, 8'h20);
		vec_ack(q);
		chk("vector low", 8'hfa, q);
		src_n <= 6'h3f;
		io_write(8'h04, 8'h00);
		io_write(8'h06, 8'ha5);
		io_write(8'h01, 8'h02);
		chk("owner irq", 8'h03, {6'h00, owner, sub_int});
		rdchk(8'h05, 8'h01, "status busy");
		rdchk(8'h06, 8'h00, "refused read");
		io_write(8'h06, 8'hff);
		sub.shift_byte(8'h3c, r);
		chk("sub rx", 8'ha5, r);
		io_write(8'h01, 8'h03);
		chk("owner back", 8'h00, {6'h00, owner, sub_int});
		rdchk(8'h06, 8'h3c, "shift buffer");
		off <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk("off float", 8'h00, {6'h00, pins_oe, db_oe});
		@(posedge clk);
		off <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk("off drive", 8'h01, {7'h00, pins_oe});
		for (i = 1; i < 3; i++)
		begin
			bus_on({i[3:0], 4'h0}, 8'h00, 1'b1, 1'b0);
			repeat (6) @(posedge clk);
			#1;
			chk("chip selects", i[7:0], {5'h00, db_oe, ser_cs_n, lcd_cs_n});
			bus_off();
		end
		// The first wrap of the counter comes about 65536 cycles in.
		while (cycles < 32'h10200) @(posedge clk);
		rdchk(8'h04, 8'h10, "pending ovf");
		io_write(8'h04, 8'h10);
		chk("irq ovf", 8'h01, {7'h00, host_irq});
		vec_ack(q);
		chk("vector ovf", 8'hf8, q);
		io_write(8'h01, 8'h04);
		rdchk(8'h04, 8'h00, "ovf cleared");
		chk("irq ovf off", 8'h00, {7'h00, host_irq});
		report_and_stop();
	end
endmodule // tb_host_io_array
